// [core/wrt_consts.svh]
// Offsets, field positions, reset values and timing counts of the wake timer
`ifndef WRT_CONSTS_SVH
`define WRT_CONSTS_SVH

// Register byte addresses
`define WRT_ADDR_CTRL        8'h20
`define WRT_ADDR_EVT0_COUNT  8'h40
`define WRT_ADDR_STATUS      8'h44
`define WRT_ADDR_MASK        8'h48

// Control register field positions
`define WRT_BIT_RC_OSC_POWER_DOWN        7
`define WRT_DLY_MSB          6
`define WRT_DLY_LSB          4
`define WRT_BIT_CAL_EN       3
`define WRT_RES_MSB          1
`define WRT_RES_LSB          0

// Reset values
`define WRT_RST_RC_OSC_POWER_DOWN        1'b1
`define WRT_RST_DELAY        3'h7
`define WRT_RST_CAL_EN       1'b1
`define WRT_RST_RES          2'h0
`define WRT_RST_EVT0_COUNT   16'h876b

// Status bit positions
`define WRT_ST_FIRST_EVENT_TIMEOUT_COUNT        0
`define WRT_ST_SECOND_EVENT_DELAY        1
`define WRT_ST_CAL_DONE      2

// Crystal clock periods per RC oscillator period
`define WRT_RC_DIV           750
// RC periods spent in the initial calibration
`define WRT_CAL_TICKS        16

`endif

// [core/wrt_pkg.sv]
// Types shared by the wake timer modules
package wrt_pkg;

  typedef enum logic [1:0] {
    WRT_OFF = 2'b00,
    WRT_CAL = 2'b01,
    WRT_RUN = 2'b10
  } wrt_state_e;

  typedef logic [31:0] wrt_word_t;

endpackage : wrt_pkg

// [core/wrt_if.sv]
// Link between the timer control and its RC clock divider
`timescale 1ns/1ns
interface wrt_if;
  logic run;
  logic rc_tick;

  modport div  (input run, output rc_tick);
  modport user (output run, input rc_tick);
endinterface : wrt_if

// [core/wrt_rc_div.sv]
// Divider that turns the crystal clock into RC period enable pulses
`timescale 1ns/1ns
`include "wrt_consts.svh"
module wrt_rc_div (
  input  wire logic I_CLK,
  input  wire logic I_SRST,
  wrt_if.div        link
);
  import wrt_pkg::*;

  localparam logic [9:0] DIV_LAST = 10'(`WRT_RC_DIV - 1);

  logic [9:0] cnt;
  logic       at_last;

  assign at_last = (cnt == DIV_LAST);

  // Counter restarts while stopped so the first period is always whole
  always_ff @(posedge I_CLK) begin
    if (I_SRST || !link.run) begin
      cnt          <= 10'h000;
      link.rc_tick <= 1'b0;
    end else begin
      cnt          <= at_last ? 10'h000 : cnt + 10'h001;
      link.rc_tick <= at_last;
    end
  end
endmodule : wrt_rc_div

// [core/wrt_top.sv]
// Wake timer control: APB registers, RC calibration and event timing
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`include "wrt_consts.svh"
module wrt_top (
  input  wire logic            I_CLK,
  input  wire logic            I_SRST,
  input  wire logic            I_PSEL,
  input  wire logic            I_PENABLE,
  input  wire logic            I_PWRITE,
  input  wire logic [7:0]      I_PADDR,
  input  wire wrt_pkg::wrt_word_t I_PWDATA,
  output logic                 O_PREADY,
  output wrt_pkg::wrt_word_t   O_PRDATA,
  output logic                 O_PSLVERR,
  output logic                 O_IRQ,
  output logic                 O_FIRST_EVENT_TIMEOUT_COUNT,
  output logic                 O_SECOND_EVENT_DELAY,
  output logic                 O_CAL_BUSY
);
  import wrt_pkg::*;

  // Control, count, status and mask fields
  logic        rc_osc_power_down;
  logic [2:0]  second_event_delay;
  logic        rc_osc_calibration_enable;
  logic [1:0]  first_event_resolution;
  logic [15:0] first_event_timeout_count;
  logic [2:0]  status;
  logic [2:0]  mask;

  // Timer state
  wrt_state_e  state;
  wrt_state_e  next_state;
  logic        pd_prev;
  logic [4:0]  cal_cnt;
  logic [14:0] pre_cnt;
  logic [15:0] step_cnt;
  logic [5:0]  e1_cnt;
  logic        e1_busy;
  logic        ev0;
  logic        ev1;
  logic        cal_done;

  wrt_if link ();

  wrt_rc_div u_div (
    .I_CLK  (I_CLK),
    .I_SRST (I_SRST),
    .link   (link.div)
  );

  // Bus decode; the answer comes one cycle into the access phase
  logic      access;
  logic      wr_en;
  logic      hit_ctrl;
  logic      hit_cnt;
  logic      hit_st;
  logic      hit_mask;
  logic      hit_any;
  wrt_word_t rd_word;
  wrt_word_t ctrl_word;

  assign access    = I_PSEL && I_PENABLE;
  assign wr_en     = access && O_PREADY && I_PWRITE && hit_any;
  assign hit_ctrl  = (I_PADDR == `WRT_ADDR_CTRL);
  assign hit_cnt   = (I_PADDR == `WRT_ADDR_EVT0_COUNT);
  assign hit_st    = (I_PADDR == `WRT_ADDR_STATUS);
  assign hit_mask  = (I_PADDR == `WRT_ADDR_MASK);
  assign hit_any   = hit_ctrl || hit_cnt || hit_st || hit_mask;
  assign ctrl_word = {24'h000000, rc_osc_power_down, second_event_delay,
                      rc_osc_calibration_enable, 1'b0,
                      first_event_resolution};
  assign rd_word   = hit_ctrl ? ctrl_word :
                     hit_cnt  ? {16'h0000, first_event_timeout_count} :
                     hit_st   ? {29'h00000000, status} :
                     hit_mask ? {29'h00000000, mask} : 32'h00000000;

  // Bus answer flops
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= access && !O_PREADY;
      O_PRDATA  <= (access && !O_PREADY && !I_PWRITE) ? rd_word : 32'h0;
      O_PSLVERR <= access && !O_PREADY && !hit_any;
    end
  end

  // Control register; bit 2 has no storage so writes to it vanish
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rc_osc_power_down         <= `WRT_RST_RC_OSC_POWER_DOWN;
      second_event_delay        <= `WRT_RST_DELAY;
      rc_osc_calibration_enable <= `WRT_RST_CAL_EN;
      first_event_resolution    <= `WRT_RST_RES;
    end else if (wr_en && hit_ctrl) begin
      rc_osc_power_down         <= I_PWDATA[`WRT_BIT_RC_OSC_POWER_DOWN];
      second_event_delay        <= I_PWDATA[`WRT_DLY_MSB:`WRT_DLY_LSB];
      rc_osc_calibration_enable <= I_PWDATA[`WRT_BIT_CAL_EN];
      first_event_resolution    <= I_PWDATA[`WRT_RES_MSB:`WRT_RES_LSB];
    end
  end

  // Count and mask registers
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      first_event_timeout_count <= `WRT_RST_EVT0_COUNT;
      mask                      <= 3'h0;
    end else begin
      if (wr_en && hit_cnt)
        first_event_timeout_count <= I_PWDATA[15:0];
      if (wr_en && hit_mask)
        mask <= I_PWDATA[2:0];
    end
  end

  // Sticky status, write one to clear; a fresh event beats the clear
  logic [2:0] events;
  logic [2:0] clr;
  assign events = {cal_done, ev1, ev0};
  assign clr    = (wr_en && hit_st) ? I_PWDATA[2:0] : 3'h0;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      status <= 3'h0;
      O_IRQ  <= 1'b0;
    end else begin
      status <= (status & ~clr) | events;
      O_IRQ  <= |(((status & ~clr) | events) & mask);
    end
  end

  // Oscillator sequencing: power up, optional calibration, then run
  logic pd_fall;
  logic cal_last;
  assign pd_fall  = pd_prev && !rc_osc_power_down;
  assign cal_last = link.rc_tick && (cal_cnt == 5'(`WRT_CAL_TICKS - 1));
  assign link.run = (state != WRT_OFF);

  always_comb begin
    next_state = state;
    case (state)
      WRT_OFF: begin
        if (pd_fall)
          next_state = rc_osc_calibration_enable ? WRT_CAL : WRT_RUN;
      end
      WRT_CAL: begin
        if (rc_osc_power_down)
          next_state = WRT_OFF;
        else if (cal_last)
          next_state = WRT_RUN;
      end
      WRT_RUN: begin
        if (rc_osc_power_down)
          next_state = WRT_OFF;
      end
      default: next_state = WRT_OFF;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state      <= WRT_OFF;
      pd_prev    <= `WRT_RST_RC_OSC_POWER_DOWN;
      cal_cnt    <= 5'h00;
      cal_done   <= 1'b0;
      O_CAL_BUSY <= 1'b0;
    end else begin
      state      <= next_state;
      pd_prev    <= rc_osc_power_down;
      cal_cnt    <= (state != WRT_CAL) ? 5'h00 :
                    link.rc_tick ? cal_cnt + 5'h01 : cal_cnt;
      cal_done   <= (state == WRT_CAL) && (next_state == WRT_RUN);
      // Busy skips the first CAL cycle, before the divider has started,
      // so it spans exactly the calibration's own RC periods
      O_CAL_BUSY <= (state == WRT_CAL) && (next_state == WRT_CAL);
    end
  end

  // Step weight in RC periods minus one, per resolution code
  logic [14:0] pre_max;
  always_comb begin
    case (first_event_resolution)
      2'h0:    pre_max = 15'h0000;
      2'h1:    pre_max = 15'h001f;
      2'h2:    pre_max = 15'h03ff;
      2'h3:    pre_max = 15'h7fff;
      default: pre_max = 15'h0000;
    endcase
  end

  // Second event delay in RC periods
  logic [5:0] dly;
  always_comb begin
    case (second_event_delay)
      3'h0:    dly = 6'h04;
      3'h1:    dly = 6'h06;
      3'h2:    dly = 6'h08;
      3'h3:    dly = 6'h0c;
      3'h4:    dly = 6'h10;
      3'h5:    dly = 6'h18;
      3'h6:    dly = 6'h20;
      3'h7:    dly = 6'h30;
      default: dly = 6'h30;
    endcase
  end

  // First event after count steps; a zero count fires every step
  logic running;
  logic step;
  logic step_last;
  assign running   = (state == WRT_RUN);
  assign step      = running && link.rc_tick && (pre_cnt >= pre_max);
  assign step_last = ({1'b0, step_cnt} + 17'h00001) >=
                     {1'b0, first_event_timeout_count};

  always_ff @(posedge I_CLK) begin
    if (I_SRST || !running) begin
      pre_cnt  <= 15'h0000;
      step_cnt <= 16'h0000;
      ev0      <= 1'b0;
      O_FIRST_EVENT_TIMEOUT_COUNT <= 1'b0;
    end else begin
      if (link.rc_tick)
        pre_cnt <= (pre_cnt >= pre_max) ? 15'h0000 : pre_cnt + 15'h0001;
      if (step)
        step_cnt <= step_last ? 16'h0000 : step_cnt + 16'h0001;
      ev0      <= step && step_last;
      O_FIRST_EVENT_TIMEOUT_COUNT <= step && step_last;
    end
  end

  // Second event counts down from the first
  always_ff @(posedge I_CLK) begin
    if (I_SRST || !running) begin
      e1_cnt   <= 6'h00;
      e1_busy  <= 1'b0;
      ev1      <= 1'b0;
      O_SECOND_EVENT_DELAY <= 1'b0;
    end else begin
      ev1      <= 1'b0;
      O_SECOND_EVENT_DELAY <= 1'b0;
      if (ev0) begin
        e1_cnt  <= dly;
        e1_busy <= 1'b1;
      end else if (e1_busy && link.rc_tick) begin
        e1_cnt <= e1_cnt - 6'h01;
        if (e1_cnt == 6'h01) begin
          e1_busy  <= 1'b0;
          ev1      <= 1'b1;
          O_SECOND_EVENT_DELAY <= 1'b1;
        end
      end
    end
  end
endmodule : wrt_top

// [bench/wrt_chk.sv]
// Port-level assertions for the wake timer control
`timescale 1ns/1ns
`include "wrt_consts.svh"
module wrt_chk (
  input wire logic               I_CLK,
  input wire logic               I_SRST,
  input wire logic               I_PSEL,
  input wire logic               I_PENABLE,
  input wire logic               I_PWRITE,
  input wire logic [7:0]         I_PADDR,
  input wire wrt_pkg::wrt_word_t I_PWDATA,
  input wire logic               O_PREADY,
  input wire wrt_pkg::wrt_word_t O_PRDATA,
  input wire logic               O_PSLVERR,
  input wire logic               O_IRQ,
  input wire logic               O_FIRST_EVENT_TIMEOUT_COUNT,
  input wire logic               O_SECOND_EVENT_DELAY,
  input wire logic               O_CAL_BUSY
);
  import wrt_pkg::*;
  logic [13:0] busy_n;
  logic [15:0] ev0_n;
  // Gap counters; the event one saturates so a stale gap never matches
  always_ff @(posedge I_CLK) begin
    busy_n <= (I_SRST || !O_CAL_BUSY) ? 14'h0 : busy_n + 14'h1;
    ev0_n <= I_SRST ? 16'hffff : O_FIRST_EVENT_TIMEOUT_COUNT ? 16'h1 :
      (ev0_n == 16'hffff) ? ev0_n : ev0_n + 16'h1;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  a_ready_wait: assert property ((I_PSEL && !I_PENABLE) ##1
    (I_PSEL && I_PENABLE) |=> O_PREADY) else $error("ready late");
  a_ready_single: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held");
  a_err_zero: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
    else $error("bad error reply");
  a_rdata_idle: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside reply");
  a_ctrl_spare: assert property (
    O_PREADY && !I_PWRITE && I_PADDR == `WRT_ADDR_CTRL |->
    O_PRDATA[2] == 1'b0 && O_PRDATA[31:8] == 24'h0)
    else $error("control spare bits set");
  a_cal_length: assert property (
    $fell(O_CAL_BUSY) |-> busy_n == `WRT_CAL_TICKS * `WRT_RC_DIV)
    else $error("calibration length wrong");
  a_event_gap: assert property (O_SECOND_EVENT_DELAY |->
    ev0_n % `WRT_RC_DIV == 0 && ev0_n >= 4 * `WRT_RC_DIV &&
    ev0_n <= 48 * `WRT_RC_DIV) else $error("second event gap wrong");
  a_first_event_timeout_count_space: assert property (
    O_FIRST_EVENT_TIMEOUT_COUNT |=> !O_FIRST_EVENT_TIMEOUT_COUNT [*8]) else $error("first events too close");
  c_second_event_delay: cover property (O_SECOND_EVENT_DELAY);
  c_err: cover property (O_PSLVERR);
  c_cal: cover property ($fell(O_CAL_BUSY));
endmodule : wrt_chk

bind wrt_top wrt_chk u_chk (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA),
  .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ), .O_FIRST_EVENT_TIMEOUT_COUNT(O_FIRST_EVENT_TIMEOUT_COUNT),
  .O_SECOND_EVENT_DELAY(O_SECOND_EVENT_DELAY), .O_CAL_BUSY(O_CAL_BUSY));

// [bench/testbench.sv]
// Self-checking bench for the wake timer control
`timescale 1ns/1ns
`include "wrt_consts.svh"
module testbench;
  import wrt_pkg::*;
  typedef struct {
    logic       w;
    logic [7:0] a;
    wrt_word_t  d;
    wrt_word_t  x;
    logic       e;
  } wrt_row_s;
  logic      clk = 1'h0, rst = 1'h1, sel = 1'h0, en = 1'h0, wr = 1'h0;
  logic [7:0] addr = 8'h0;
  wrt_word_t wd = 32'h0, rd, prdata;
  logic      rdy, err, er, irq, e0, e1, busy;
  int        n_mismatch = 0, checks = 0, n;
  // Plain accesses: write, address, write data, read value, error
  wrt_row_s rows [12] = '{
    '{1'h0, 8'h20, 32'h0, 32'hf8, 1'h0}, '{1'h0, 8'h40, 32'h0, 32'h876b, 1'h0},
    '{1'h0, 8'h44, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h48, 32'h0, 32'h0, 1'h0},
    '{1'h1, 8'h20, 32'hfc, 32'h0, 1'h0}, '{1'h0, 8'h20, 32'h0, 32'hf8, 1'h0},
    '{1'h1, 8'h20, 32'ha2, 32'h0, 1'h0}, '{1'h0, 8'h20, 32'h0, 32'ha2, 1'h0},
    '{1'h1, 8'h20, 32'hdb, 32'h0, 1'h0}, '{1'h0, 8'h20, 32'h0, 32'hdb, 1'h0},
    '{1'h0, 8'h24, 32'h0, 32'h0, 1'h1}, '{1'h1, 8'h30, 32'hff, 32'h0, 1'h1}};

  wrt_top u_dut (
    .I_CLK(clk), .I_SRST(rst), .I_PSEL(sel), .I_PENABLE(en),
    .I_PWRITE(wr), .I_PADDR(addr), .I_PWDATA(wd), .O_PREADY(rdy),
    .O_PRDATA(prdata), .O_PSLVERR(err), .O_IRQ(irq), .O_FIRST_EVENT_TIMEOUT_COUNT(e0),
    .O_SECOND_EVENT_DELAY(e1), .O_CAL_BUSY(busy));

  // 20 MHz crystal clock
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic hang;
    n_mismatch++;
    test_done;
  endtask : hang

  // One APB transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input wrt_word_t d);
    int i = 0;
    @(posedge clk);
    sel <= 1'h1;
    wr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1'h1;
    do begin
      @(posedge clk);
      i++;
    end while (rdy !== 1'h1 && i < 20);
    rd = prdata;
    er = err;
    sel <= 1'h0;
    en <= 1'h0;
    if (rdy !== 1'h1)
      hang;
  endtask : apb

  // Count edges until an event, or the end of calibration, is seen
  task automatic wt(input int s, input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((s == 0 ? e0 : s == 1 ? e1 : !busy) !== 1'h1 && n < lim);
    if (n >= lim)
      hang;
  endtask : wt

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(er, rows[i].e);
      if (!rows[i].w)
        chk(rd, rows[i].x);
    end
    // Calibration off, count 8, second event code 0
    apb(1'h1, 8'h40, 32'h8);
    apb(1'h1, 8'h20, 32'h0);
    repeat (4) @(posedge clk);
    chk(busy, 1'h0);
    wt(0, 7000);
    wt(1, 4000);
    chk(n, 4 * `WRT_RC_DIV);
    wt(0, 4000);
    chk(n, 4 * `WRT_RC_DIV);
    apb(1'h0, 8'h44, 32'h0);
    chk(rd & 32'h3, 32'h3);
    chk(irq, 1'h0);
    // Coarse resolution, count 1, second event code 1
    apb(1'h1, 8'h40, 32'h1);
    apb(1'h1, 8'h20, 32'h11);
    wt(0, 30000);
    wt(1, 6000);
    chk(n, 6 * `WRT_RC_DIV);
    wt(0, 30000);
    chk(n, 26 * `WRT_RC_DIV);
    // Stop, clear status, then release with calibration enabled
    apb(1'h1, 8'h20, 32'h89);
    apb(1'h1, 8'h44, 32'h7);
    apb(1'h1, 8'h20, 32'h9);
    repeat (4) @(posedge clk);
    chk(busy, 1'h1);
    wt(2, 13000);
    apb(1'h0, 8'h44, 32'h0);
    chk(rd, 32'h4);
    chk(irq, 1'h0);
    apb(1'h1, 8'h48, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'h1);
    apb(1'h1, 8'h44, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'h0);
    // Reset in mid-run stops the timer and restores the control fields
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(busy, 1'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk(rd, 32'hf8);
    repeat (4) @(posedge clk);
    chk(busy, 1'h0);
    test_done;
  end
endmodule : testbench
